// file: iasc_pkg.sv
package iasc_pkg;
  // class of the instruction that has just completed, from the core sequencer
  typedef enum logic [3:0] {
    IC_PLAIN, IC_SS_LOAD, IC_SEG_PREFIX, IC_REP_PREFIX, IC_LOCK_PREFIX,
    IC_ENABLE_INT, IC_DISABLE_INT, IC_PSW_LOAD, IC_HALT
  } iasc_class_e;

  // block instruction in progress
  typedef enum logic [3:0] {
    BK_MOVW, BK_MOVB, BK_BLOCK_COMPARE_WORD_INSTR, BK_CMPBKB, BK_MEMORY_COMPARE_WORD_INSTR, BK_CMPMB,
    BK_STRING_LOAD_WORD_INSTR, BK_LDMB, BK_STRING_STORE_WORD_INSTR, BK_STMB, BK_INBLK
  } iasc_blk_e;

  typedef enum logic [1:0] {ST_RUN, ST_HALT_STATUS, ST_STANDBY, ST_HOLD} iasc_state_e;

  // register map of the plain software port
  localparam logic [3:0]  IASC_OFS_CTRL     = 4'h0;
  localparam logic [3:0]  IASC_OFS_STATUS   = 4'h4;
  localparam logic [3:0]  IASC_OFS_PREFIX   = 4'h8;
  localparam int          IASC_CTRL_BLKEN   = 0;
  localparam logic        IASC_CTRL_RESET   = 1'b1;

  // bus status codes and vectors
  localparam logic [3:0]  IASC_BS_HALT      = 4'h3;
  localparam logic [3:0]  IASC_BS_IDLE      = 4'hF;
  localparam logic [7:0]  IASC_VEC_TRAP     = 8'h01;
  localparam logic [7:0]  IASC_VEC_NMI      = 8'h02;
  localparam int          IASC_HALT_CLKS    = 1;

  // bus cycles until a request is taken, worst case, index {srcOdd, dstOdd} for four-entry tables, one operand's parity for two-entry ones
  localparam logic [3:0]  IASC_DLY_MOVW [4] = '{4'h4, 4'h6, 4'h5, 4'h7};
  localparam logic [3:0]  IASC_DLY_BLOCK_COMPARE_WORD_INSTR[4] = '{4'h2, 4'h3, 4'h3, 4'h4};
  localparam logic [3:0]  IASC_DLY_MEMORY_COMPARE_WORD_INSTR[2] = '{4'h1, 4'h2};
  localparam logic [3:0]  IASC_DLY_STRING_LOAD_WORD_INSTR [2] = '{4'h1, 4'h2};
  localparam logic [3:0]  IASC_DLY_STRING_STORE_WORD_INSTR [2] = '{4'h4, 4'h5};
  localparam logic [3:0]  IASC_DLY_MOVB     = 4'h4;
  localparam logic [3:0]  IASC_DLY_CMPBKB   = 4'h2;
  localparam logic [3:0]  IASC_DLY_SHORT    = 4'h1;
  localparam logic [3:0]  IASC_DLY_STMB     = 4'h4;
  localparam logic [3:0]  IASC_DLY_INBLK    = 4'h4;
endpackage : iasc_pkg

// file: iasc_blk_if.sv
`timescale 1ns/1ps
interface iasc_blk_if;
  import iasc_pkg::*;
  logic      req;
  logic      active;
  logic      busCycle;
  iasc_blk_e kind;
  logic      srcOdd;
  logic      dstOdd;
  logic      accept;
  modport ctrl (output req, active, busCycle, kind, srcOdd, dstOdd, input accept);
  modport dly  (input req, active, busCycle, kind, srcOdd, dstOdd, output accept);
endinterface : iasc_blk_if

// file: iasc_block_delay.sv
`timescale 1ns/1ps
module iasc_block_delay import iasc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // link to the acceptance controller
  iasc_blk_if.dly  blk
);
  typedef struct packed {
    logic       armed;
    logic [3:0] cnt;
  } iasc_dly_s;

  iasc_dly_s s;
  iasc_dly_s next_s;
  logic [3:0] limit;
  logic [3:0] effCnt;
  logic       live;

  // worst-case figure per instruction and operand parity
  always_comb begin
    case (blk.kind)
      BK_MOVW:   limit = IASC_DLY_MOVW[{blk.srcOdd, blk.dstOdd}];
      BK_MOVB:   limit = IASC_DLY_MOVB;
      BK_BLOCK_COMPARE_WORD_INSTR: limit = IASC_DLY_BLOCK_COMPARE_WORD_INSTR[{blk.srcOdd, blk.dstOdd}];
      BK_CMPBKB: limit = IASC_DLY_CMPBKB;
      BK_MEMORY_COMPARE_WORD_INSTR:  limit = IASC_DLY_MEMORY_COMPARE_WORD_INSTR[blk.dstOdd];
      BK_STRING_LOAD_WORD_INSTR:   limit = IASC_DLY_STRING_LOAD_WORD_INSTR[blk.srcOdd];
      BK_STRING_STORE_WORD_INSTR:   limit = IASC_DLY_STRING_STORE_WORD_INSTR[blk.dstOdd];
      BK_STMB:   limit = IASC_DLY_STMB;
      BK_INBLK:  limit = IASC_DLY_INBLK;
      default:   limit = IASC_DLY_SHORT;
    endcase
  end

  // the bus cycle in which the request shows up already counts as one
  assign live       = s.armed || blk.req;
  assign effCnt     = s.armed ? s.cnt : 4'h1;
  assign blk.accept = blk.active && blk.req && live && blk.busCycle && (effCnt >= limit);

  always_comb begin
    next_s = s;
    if (!blk.active || !blk.req || blk.accept) begin
      next_s = '0;
    end else begin
      next_s.armed = 1'b1;
      next_s.cnt   = blk.busCycle ? 4'(effCnt + 4'h1) : effCnt;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  a_accept_bound: assert property (@(posedge clk) disable iff (!reset_n)
    blk.accept && (limit > 4'h1) |-> $past(blk.active && blk.req))
    else $error("block accept in the bus cycle the request arrived");
endmodule : iasc_block_delay

// file: iasc_accept_ctrl.sv
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module iasc_accept_ctrl import iasc_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // software register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdData,
  // core sequencer
  input  wire logic        instrDone,
  input  wire iasc_class_e instrClass,
  input  wire logic        pswLoadIe,
  input  wire logic        pswLoadTrap,
  input  wire logic        blockActive,
  input  wire iasc_blk_e   blockKind,
  input  wire logic        srcOdd,
  input  wire logic        dstOdd,
  input  wire logic        busCycleDone,
  input  wire logic [3:0]  coreBusStatus,
  input  wire logic [19:0] coreAddr,
  input  wire logic        coreUpperByteEnable_n,
  input  wire logic [15:0] coreData,
  // requests back to the sequencer
  output logic             takeNmi,
  output logic             takeInt,
  output logic             takeTrap,
  output logic             suspendBlock,
  output logic             standbyRelease,
  output logic      [7:0]  vector,
  output logic      [1:0]  retAdjust,
  output logic             coreClockRun,
  output logic             interruptEnableFlag,
  output logic             singleStepTrapFlag,
  // pins
  input  wire logic        nmiPin,
  input  wire logic        intPin,
  input  wire logic        holdReqPin,
  output logic      [3:0]  busStatusOutputs,
  output logic      [19:0] addressOutputLines,
  output logic             upperByteEnable_n,
  output logic      [15:0] dataOutputLines,
  output logic             holdAck
);
  typedef struct packed {
    iasc_state_e state;
    logic        ie;
    logic        trap;
    logic        trapArmed;
    logic        lastInhibit;
    logic [2:0]  prefixKinds;
    logic        skipStandby;
    logic        nmiSync1;
    logic        nmiSync2;
    logic        nmiPrev;
    logic        nmiPending;
    logic        intSync1;
    logic        intSync2;
    logic        holdSync1;
    logic        holdSync2;
    logic        blockIntEn;
    logic        takeNmi;
    logic        takeInt;
    logic        takeTrap;
    logic        suspend;
    logic        exitStandby;
    logic [7:0]  vector;
    logic [1:0]  retAdjust;
    logic [3:0]  busStatus;
    logic [19:0] addr;
    logic        ube_n;
    logic [15:0] data;
    logic        holdAck;
    logic [31:0] rdData;
  } iasc_ctrl_s;

  localparam iasc_ctrl_s IASC_RESET_STATE = '{
    state: ST_RUN, blockIntEn: IASC_CTRL_RESET, busStatus: IASC_BS_IDLE,
    addr: '1, ube_n: 1'b1, default: '0};

  iasc_ctrl_s s;
  iasc_ctrl_s next_s;
  iasc_blk_if blk ();

  logic       inhibitAll;
  logic       inhibitInt;
  logic       newIe;
  logic       newTrap;
  logic       intOk;
  logic       intReq;
  logic [1:0] prefixCount;

  // boundary decode: the boundary right after these instructions takes nothing
  always_comb begin
    inhibitAll = (instrClass == IC_SS_LOAD)
              || (instrClass == IC_SEG_PREFIX)
              || (instrClass == IC_REP_PREFIX)
              || (instrClass == IC_LOCK_PREFIX);
    newIe   = s.ie;
    newTrap = s.trap;
    case (instrClass)
      IC_ENABLE_INT:  newIe = 1'b1;
      IC_DISABLE_INT: newIe = 1'b0;
      IC_PSW_LOAD: begin
        newIe   = pswLoadIe;
        newTrap = pswLoadTrap;
      end
      default: newIe = s.ie;
    endcase
    // only a 0 to 1 change holds off the maskable line
    inhibitInt = ((instrClass == IC_ENABLE_INT) || (instrClass == IC_PSW_LOAD))
              && !s.ie && newIe;
  end

  assign intReq      = s.intSync2;             // line held by requester
  // the flag as the instruction leaves it decides, so a clear at this boundary already masks
  assign intOk       = !inhibitAll && !inhibitInt && s.ie && newIe && intReq;
  assign prefixCount = 2'(s.prefixKinds[0]) + 2'(s.prefixKinds[1]) + 2'(s.prefixKinds[2]);

  // block-instruction delay counter sees only hardware requests
  assign blk.req      = s.blockIntEn && (s.nmiPending || (s.ie && intReq));
  assign blk.active   = blockActive && (s.state == ST_RUN) && !instrDone;
  assign blk.busCycle = busCycleDone;
  assign blk.kind     = blockKind;
  assign blk.srcOdd   = srcOdd;
  assign blk.dstOdd   = dstOdd;

  iasc_block_delay u_delay (
    .clk     (clk),
    .reset_n (reset_n),
    .blk     (blk.dly)
  );

  // whole next state
  always_comb begin
    next_s           = s;
    next_s.takeNmi   = 1'b0;
    next_s.takeInt   = 1'b0;
    next_s.takeTrap  = 1'b0;
    next_s.suspend   = 1'b0;
    next_s.exitStandby = 1'b0;
    next_s.rdData    = '0;
    // two-flop synchronisers for the pins
    next_s.nmiSync1  = nmiPin;
    next_s.nmiSync2  = s.nmiSync1;
    next_s.nmiPrev   = s.nmiSync2;
    next_s.intSync1  = intPin;
    next_s.intSync2  = s.intSync1;
    next_s.holdSync1 = holdReqPin;
    next_s.holdSync2 = s.holdSync1;

    case (s.state)
      ST_RUN: begin
        if (instrDone) begin
          next_s.ie          = newIe;
          next_s.trap        = newTrap;
          next_s.trapArmed   = newTrap;          // flag seen by the next instruction
          next_s.lastInhibit = inhibitAll || inhibitInt;
          case (instrClass)
            IC_SEG_PREFIX:  next_s.prefixKinds[0] = 1'b1;
            IC_REP_PREFIX:  next_s.prefixKinds[1] = 1'b1;
            IC_LOCK_PREFIX: next_s.prefixKinds[2] = 1'b1;
            default:        next_s.prefixKinds    = '0;
          endcase
          // arbitration at the boundary
          if (!inhibitAll && s.nmiPending) begin
            next_s.takeNmi    = 1'b1;
            next_s.vector     = IASC_VEC_NMI;
            next_s.nmiPending = 1'b0;
          end else if (intOk) begin
            next_s.takeInt = 1'b1;
          end else if (!inhibitAll && s.trapArmed) begin
            next_s.takeTrap = 1'b1;
            next_s.vector   = IASC_VEC_TRAP;
          end
          next_s.retAdjust = '0;
          if (instrClass == IC_HALT) begin
            next_s.state       = ST_HALT_STATUS;
            next_s.skipStandby = s.nmiPending || intReq;
          end
        end else if (blk.accept) begin
          // suspend a block instruction mid-way, prefixes replayed on return
          next_s.suspend   = 1'b1;
          next_s.retAdjust = prefixCount;
          if (s.nmiPending) begin
            next_s.takeNmi    = 1'b1;
            next_s.vector     = IASC_VEC_NMI;
            next_s.nmiPending = 1'b0;
          end else begin
            next_s.takeInt = 1'b1;
          end
        end
      end
      ST_HALT_STATUS: begin
        next_s.state = s.skipStandby ? ST_RUN : ST_STANDBY;
      end
      ST_STANDBY: begin
        if (s.holdSync2) begin
          next_s.state = ST_HOLD;
        end else if (s.nmiPending) begin
          next_s.state      = ST_RUN;
          next_s.exitStandby = 1'b1;
          next_s.takeNmi    = 1'b1;
          next_s.vector     = IASC_VEC_NMI;
          next_s.nmiPending = 1'b0;
        end else if (intReq) begin
          next_s.state   = ST_RUN;
          next_s.exitStandby = 1'b1;
          next_s.takeInt = s.ie;
        end
      end
      default: begin
        // hold ends: straight back to standby, no second halt code
        if (!s.holdSync2) begin
          next_s.state = ST_STANDBY;
        end
      end
    endcase

    // every entry clears both flags
    if (next_s.takeNmi || next_s.takeInt || next_s.takeTrap) begin
      next_s.ie        = 1'b0;
      next_s.trap      = 1'b0;
      next_s.trapArmed = 1'b0;
    end
    // edge seen after the clear still counts, the set wins
    if (s.nmiSync2 && !s.nmiPrev) begin
      next_s.nmiPending = 1'b1;
    end

    // pins follow the state they are entering, so they line up with it
    case (next_s.state)
      ST_RUN: begin
        next_s.busStatus = coreBusStatus;
        next_s.addr      = coreAddr;
        next_s.ube_n     = coreUpperByteEnable_n;
        next_s.data      = coreData;
        next_s.holdAck   = 1'b0;
      end
      ST_HALT_STATUS: begin
        next_s.busStatus = IASC_BS_HALT;
        next_s.holdAck   = 1'b0;
      end
      default: begin
        next_s.busStatus = IASC_BS_IDLE;
        next_s.addr      = '1;
        next_s.ube_n     = 1'b1;
        next_s.holdAck   = (next_s.state == ST_HOLD);
      end
    endcase

    // register port
    if (regWr && (regAddr == IASC_OFS_CTRL)) begin
      next_s.blockIntEn = regWrData[IASC_CTRL_BLKEN];
    end
    if (regRd) begin
      if (regAddr == IASC_OFS_CTRL) begin
        next_s.rdData = {31'h0, s.blockIntEn};
      end else if (regAddr == IASC_OFS_STATUS) begin
        next_s.rdData = {25'h0, s.state, s.holdAck, s.lastInhibit, s.nmiPending, s.trap, s.ie};
      end else if (regAddr == IASC_OFS_PREFIX) begin
        next_s.rdData = {27'h0, s.prefixKinds, s.retAdjust};
      end
    end
  end

  // synchronous reset drops any halted context
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= IASC_RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  assign regRdData           = s.rdData;
  assign takeNmi             = s.takeNmi;
  assign takeInt             = s.takeInt;
  assign takeTrap            = s.takeTrap;
  assign suspendBlock        = s.suspend;
  assign standbyRelease      = s.exitStandby;
  assign vector              = s.vector;
  assign retAdjust           = s.retAdjust;
  assign interruptEnableFlag = s.ie;
  assign singleStepTrapFlag  = s.trap;
  // everything but release and hold logic stops while halted
  assign coreClockRun        = (s.state == ST_RUN) || (s.state == ST_HALT_STATUS);
  assign busStatusOutputs    = s.busStatus;
  assign addressOutputLines  = s.addr;
  assign upperByteEnable_n   = s.ube_n;
  assign dataOutputLines     = s.data;
  assign holdAck             = s.holdAck;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_trap_after_one: assert property (
    (s.state == ST_RUN) && instrDone && s.trapArmed && !inhibitAll && !s.nmiPending && !intOk
    |=> takeTrap && (vector == IASC_VEC_TRAP))
    else $error("armed trap not taken at the boundary");
  a_entry_clears_flags: assert property (
    (takeTrap || takeNmi || takeInt) |-> !interruptEnableFlag && !singleStepTrapFlag)
    else $error("flags left set on interrupt entry");
  a_trap_only_reload: assert property (
    $rose(singleStepTrapFlag) |-> $past(instrDone && (instrClass == IC_PSW_LOAD)))
    else $error("trap flag set without a status reload");
  a_prefix_no_take: assert property (
    (s.state == ST_RUN) && instrDone && inhibitAll |=> !takeNmi && !takeInt && !takeTrap)
    else $error("interrupt taken right after a prefix or stack load");
  a_ei_blocks_int: assert property (
    (s.state == ST_RUN) && instrDone && inhibitInt |=> !takeInt)
    else $error("maskable taken right after the enable flag rose");
  a_nmi_held: assert property (
    (s.state == ST_RUN) && instrDone && inhibitAll && s.nmiPending |=> s.nmiPending)
    else $error("pending nmi lost in an inhibit window");
  a_halt_code_once: assert property (
    (busStatusOutputs == IASC_BS_HALT) && (s.state == ST_HALT_STATUS) && !s.skipStandby
    |=> (busStatusOutputs == IASC_BS_IDLE) && (addressOutputLines == 20'hFFFFF) && !coreClockRun)
    else $error("standby entry not shown as one halt clock then idle");
  a_hold_first: assert property (
    (s.state == ST_STANDBY) && s.holdSync2 |=> holdAck && !standbyRelease ##1 holdAck || !s.holdSync2)
    else $error("hold not granted ahead of release");
  a_release_noie: assert property (
    (s.state == ST_STANDBY) && !s.holdSync2 && !s.nmiPending && s.intSync2 && !s.ie
    |=> standbyRelease && !takeInt && coreClockRun)
    else $error("disabled maskable did not release without service");
  a_hold_back_idle: assert property (
    (s.state == ST_HOLD) && !s.holdSync2 |=> (busStatusOutputs == IASC_BS_IDLE) && !holdAck)
    else $error("hold end did not return to idle standby");

  c_trap_taken:    cover property (takeTrap);
  c_block_suspend: cover property (suspendBlock && (retAdjust != 2'h0));
  c_standby_nmi:   cover property ((s.state == ST_STANDBY) ##1 (standbyRelease && takeNmi));
  c_hold_standby:  cover property ((s.state == ST_HOLD) ##1 (s.state == ST_STANDBY));
endmodule : iasc_accept_ctrl

// file: iasc_far_model.sv
`timescale 1ns/1ps
module iasc_far_model (
  // clock
  input  wire logic       clk,
  // bench commands, one-cycle pulses, and the hold lag that stays set
  input  wire logic       wantInt,
  input  wire logic       wantNmi,
  input  wire logic       wantHold,
  input  wire logic [3:0] lag,
  // answers from the core
  input  wire logic       takeInt,
  input  wire logic       standbyRelease,
  input  wire logic       holdAck,
  // pins of the core
  output logic            intPin,
  output logic            nmiPin,
  output logic            holdReqPin
);
  logic [3:0] holdCnt;

  initial begin
    {intPin, nmiPin, holdReqPin} = 3'b000;
    holdCnt = 4'h0;
  end

  // the level request stays up until the core answers, since a lost request is never retried
  always @(posedge clk) begin
    if (wantInt) begin
      intPin <= 1'b1;
    end else if (takeInt || standbyRelease) begin
      intPin <= 1'b0;
    end
    nmiPin <= wantNmi;
    // a slow requester keeps the bus lag cycles after the grant
    if (wantHold) begin
      holdReqPin <= 1'b1;
    end else if (holdAck && holdReqPin) begin
      holdCnt <= holdCnt + 4'h1;
      if (holdCnt >= lag) holdReqPin <= 1'b0;
    end else begin
      holdCnt <= 4'h0;
    end
  end
endmodule : iasc_far_model

// file: iasc_accept_ctrl_bench.sv
`timescale 1ns/1ps
module iasc_accept_ctrl_bench import iasc_pkg::*; ;
  logic        clk, reset_n, regWr, regRd, instrDone, pswLoadIe, pswLoadTrap, wantInt, wantNmi;
  logic        blockActive, srcOdd, dstOdd, busCycleDone, wantHold, takeNmi, takeInt, takeTrap;
  logic        suspendBlock, standbyRelease, coreClockRun, interruptEnableFlag, singleStepTrapFlag;
  logic        upperByteEnable_n, holdAck, nmiPin, intPin, holdReqPin, mIe, mTrap, mNmi, mInt;
  logic        coreUpperByteEnable_n;
  logic [3:0]  regAddr, busStatusOutputs, lag, coreBusStatus;
  logic [31:0] regWrData, regRdData;
  logic [19:0] coreAddr, addressOutputLines;
  logic [15:0] coreData, dataOutputLines;
  logic [7:0]  vector;
  logic [1:0]  retAdjust;
  iasc_class_e instrClass;
  iasc_blk_e   blockKind;
  int          numErrors, nChecks, nb, n, lim;
  iasc_class_e inh[4] = '{IC_SS_LOAD, IC_SEG_PREFIX, IC_REP_PREFIX, IC_LOCK_PREFIX};
  iasc_blk_e   bk[4]  = '{BK_MOVW, BK_MOVB, BK_CMPBKB, BK_STMB};
  logic [3:0]  lt[4]  = '{4'h0, IASC_DLY_MOVB, IASC_DLY_CMPBKB, IASC_DLY_STMB};

  iasc_accept_ctrl i_iasc_accept_ctrl (.clk, .reset_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .instrDone, .instrClass, .pswLoadIe, .pswLoadTrap, .blockActive, .blockKind, .srcOdd, .dstOdd,
    .busCycleDone, .coreBusStatus, .coreAddr, .coreUpperByteEnable_n, .coreData,
    .takeNmi, .takeInt, .takeTrap, .suspendBlock, .standbyRelease, .vector, .retAdjust, .coreClockRun,
    .interruptEnableFlag, .singleStepTrapFlag, .nmiPin, .intPin, .holdReqPin, .busStatusOutputs,
    .addressOutputLines, .upperByteEnable_n, .dataOutputLines, .holdAck);
  iasc_far_model i_iasc_far_model (.clk, .wantInt, .wantNmi, .wantHold, .lag, .takeInt, .standbyRelease,
    .holdAck, .intPin, .nmiPin, .holdReqPin);

  // free-running core clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    nChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : reportAndStop

  // one register access; read data stands only in the following cycle
  task automatic regAccess(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [31:0] exp);
    @(posedge clk);
    {regWr, regRd, regAddr, regWrData} <= {wr, !wr, a, d};
    @(posedge clk);
    {regWr, regRd} <= 2'b00;
    #1;
    if (!wr) check(regRdData, exp);
  endtask : regAccess

  task automatic doReset();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    check({busStatusOutputs, holdAck, coreClockRun}, {IASC_BS_IDLE, 2'b01});
    {mIe, mTrap, mNmi, mInt} = 4'h0;
  endtask : doReset

  // one instruction boundary against the reference model of flags and pending requests
  task automatic step(input iasc_class_e cls, input logic ie = 1'b0, input logic tr = 1'b0);
    logic inhib, nIe, eN, eI, eT;
    inhib = cls inside {IC_SS_LOAD, IC_SEG_PREFIX, IC_REP_PREFIX, IC_LOCK_PREFIX};
    nIe = (cls == IC_PSW_LOAD) ? ie : (cls == IC_ENABLE_INT) ? 1'b1 : (cls == IC_DISABLE_INT) ? 1'b0 : mIe;
    eN = mNmi && !inhib;
    eI = !eN && mInt && nIe && mIe && !inhib;
    eT = !eN && !eI && mTrap && !inhib;
    @(posedge clk);
    instrClass <= cls;
    {instrDone, pswLoadIe, pswLoadTrap} <= {1'b1, ie, tr};
    {coreAddr, coreData, coreBusStatus, coreUpperByteEnable_n} <= 41'({$urandom, $urandom});
    @(posedge clk);
    instrDone <= 1'b0;
    #1;
    {mIe, mTrap} = (eN | eI | eT) ? 2'b00 : {nIe, (cls == IC_PSW_LOAD) ? tr : mTrap};
    {mNmi, mInt} = {mNmi & !eN, mInt & !eI};
    check({takeNmi, takeInt, takeTrap}, {eN, eI, eT});
    if (eN | eT) check(vector, eN ? IASC_VEC_NMI : IASC_VEC_TRAP);
    check({interruptEnableFlag, singleStepTrapFlag}, {mIe, mTrap});
    check({addressOutputLines, dataOutputLines, busStatusOutputs, upperByteEnable_n},
          {coreAddr, coreData, coreBusStatus, coreUpperByteEnable_n});
  endtask : step

  // pulse the far side, then let the synchronisers settle
  task automatic kick(input logic i, input logic m, input logic h, input int post);
    @(posedge clk);
    {wantInt, wantNmi, wantHold, lag} <= {i, m, h, 4'($urandom % 4)};
    @(posedge clk);
    {wantInt, wantNmi, wantHold} <= 3'b000;
    repeat (post) @(posedge clk);
    {mInt, mNmi} = {mInt | i, mNmi | m};
  endtask : kick

  task automatic halt(input logic sleeps);
    @(posedge clk);
    instrDone     <= 1'b1;
    instrClass    <= IC_HALT;
    coreBusStatus <= IASC_BS_IDLE; // the core shows idle when standby hands the pins back
    @(posedge clk);
    instrDone <= 1'b0;
    #1;
    check(busStatusOutputs, IASC_BS_HALT);
    @(posedge clk);
    #1;
    check(coreClockRun, !sleeps);
    if (sleeps) check({busStatusOutputs, addressOutputLines, upperByteEnable_n}, {24'hFFFFFF, 1'b1});
  endtask : halt

  // bounded wait for the way out of standby; the halt code must not come back meanwhile
  task automatic waitRelease(input logic eN, input logic eI);
    for (int i = 0; i < 40 && standbyRelease !== 1'b1; i++) begin
      @(posedge clk);
      #1;
      check(busStatusOutputs, IASC_BS_IDLE);
      if (holdAck === 1'b1) nb = 1;
    end
    check({standbyRelease, takeNmi, takeInt, holdAck}, {1'b1, eN, eI, 1'b0});
    {mIe, mTrap} = (eN | eI) ? 2'b00 : {mIe, mTrap};
    {mNmi, mInt} = 2'b00;
    @(posedge clk);
    #1;
    check(coreClockRun, 1'b1);
  endtask : waitRelease

  // hang guard, far above the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    numErrors++;
    reportAndStop();
  end

  initial begin
    {regWr, regRd, instrDone, pswLoadIe, pswLoadTrap, blockActive, srcOdd, dstOdd} = 8'h00;
    {busCycleDone, wantInt, wantNmi, wantHold, reset_n, mIe, mTrap, mNmi, mInt} = 9'h000;
    {regAddr, regWrData, coreAddr, coreData, lag} = '0;
    {coreBusStatus, coreUpperByteEnable_n} = 5'h1F;
    instrClass = IC_PLAIN;
    blockKind  = BK_MOVW;
    {numErrors, nChecks} = 64'h0;
    nb = $urandom(36585);
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    check({busStatusOutputs, addressOutputLines, upperByteEnable_n, holdAck, coreClockRun}, 27'h7FFFFFD);
    check({interruptEnableFlag, singleStepTrapFlag, regRdData}, 34'h0);
    regAccess(0, IASC_OFS_CTRL, 0, 32'h1);
    regAccess(1, IASC_OFS_STATUS, 32'hFFFFFFFF, 0);
    regAccess(0, IASC_OFS_STATUS, 0, 0);
    regAccess(0, 4'hC, 0, 0);
    regAccess(1, IASC_OFS_CTRL, 0, 0);
    regAccess(0, IASC_OFS_CTRL, 0, 0);
    regAccess(1, IASC_OFS_CTRL, 32'h1, 0);
    $display("test registers done");
    foreach (inh[k]) begin
      step(IC_PSW_LOAD, 1'b0, 1'b1);
      step(inh[k]);
      step(IC_PLAIN);
    end
    $display("test single step done");
    kick(1, 0, 0, 5);
    step(IC_PSW_LOAD, 1'b1, 1'b0);
    step(IC_PLAIN);
    kick(0, 0, 0, 6);
    step(IC_ENABLE_INT);
    step(IC_DISABLE_INT);
    kick(1, 0, 0, 5);
    step(IC_PLAIN);
    step(IC_ENABLE_INT);
    step(IC_ENABLE_INT);
    step(IC_PSW_LOAD, 1'b1, 1'b1);
    kick(1, 1, 0, 6);
    step(IC_LOCK_PREFIX);
    step(IC_PLAIN);
    step(IC_PSW_LOAD, 1'b1, 1'b1);
    step(IC_PLAIN);
    $display("test boundaries done");
    kick(0, 0, 0, 6);
    halt(1);
    kick(1, 0, 0, 0);
    waitRelease(0, 0);
    step(IC_ENABLE_INT);
    halt(1);
    kick(1, 0, 0, 0);
    waitRelease(0, 1);
    kick(0, 0, 0, 2); // the released int line must drain the synchronisers first
    halt(1);
    kick(0, 1, 0, 0);
    waitRelease(1, 0);
    step(IC_ENABLE_INT);
    halt(1);
    nb = 0;
    kick(1, 0, 1, 0);
    waitRelease(0, 1);
    check(nb, 1);
    kick(0, 1, 0, 6);
    halt(0);
    doReset();
    halt(1);
    doReset();
    regAccess(0, IASC_OFS_STATUS, 0, 0);
    $display("test standby done");
    foreach (bk[k]) begin
      n = $urandom % 4;
      step(IC_ENABLE_INT);
      for (int j = 0; j < n; j++) step(inh[j + 1]);
      @(posedge clk);
      {blockActive, srcOdd, dstOdd} <= {1'b1, 2'($urandom)};
      blockKind <= bk[k];
      kick(1, 0, 0, 4);
      lim = (bk[k] == BK_MOVW) ? int'(IASC_DLY_MOVW[{srcOdd, dstOdd}]) : int'(lt[k]);
      nb = 0;
      while (suspendBlock !== 1'b1 && nb < 9) begin
        @(posedge clk);
        busCycleDone <= 1'b1;
        nb++;
        @(posedge clk);
        busCycleDone <= 1'b0;
        #1;
      end
      check({suspendBlock, takeInt, retAdjust}, {2'b11, n[1:0]});
      check(nb, lim);
      @(posedge clk);
      blockActive <= 1'b0;
      {mIe, mInt} = 2'b00;
      kick(0, 0, 0, 4);
    end
    $display("test block suspend done");
    reportAndStop();
  end
endmodule : iasc_accept_ctrl_bench
